// ---- design/rcb_pkg.sv ----
// package of constants and types for the receive signaling buffer
package rcb_pkg;

    // ****************************************
    // apb register map (byte addresses)
    // ****************************************
    localparam logic [11:0] RCB_ADDR_CFG = 12'h000;
    localparam logic [11:0] RCB_ADDR_ACC = 12'h004;
    localparam logic [11:0] RCB_ADDR_DATA = 12'h008;
    localparam logic [11:0] RCB_ADDR_STAT = 12'h00c;
    localparam logic [11:0] RCB_ADDR_COS = 12'h010;

    // ****************************************
    // field positions
    // ****************************************
    localparam int RCB_CFG_FMT_LSB = 0;
    localparam int RCB_CFG_DEB_BIT = 4;
    localparam int RCB_CFG_HOLD_BIT = 5;
    localparam int RCB_CFG_SIXTEEN_STATE_SELECT_BIT = 6;
    localparam int RCB_CFG_STATE_CHANGE_IRQ_ENABLE_BIT = 7;
    localparam int RCB_ACC_RWN_BIT = 7;
    localparam int RCB_IND_CAP_BIT = 4;
    localparam int RCB_STAT_BUSY_BIT = 0;

    // ****************************************
    // framing formats
    // ****************************************
    localparam logic [2:0] RCB_FMT_SF = 3'h0;
    localparam logic [2:0] RCB_FMT_ESF = 3'h1;
    localparam logic [2:0] RCB_FMT_SLC = 3'h2;
    localparam logic [2:0] RCB_FMT_DM = 3'h3;
    localparam logic [2:0] RCB_FMT_E1 = 3'h4;

    // ****************************************
    // frame and slot figures
    // ****************************************
    localparam logic [6:0] RCB_SIG_STEP = 7'h06;
    localparam logic [6:0] RCB_SF_LAST = 7'h0c;
    localparam logic [6:0] RCB_ESF_LAST = 7'h18;
    localparam logic [4:0] RCB_T1_CHANNELS = 5'h18;
    localparam logic [4:0] RCB_E1_SIG_TS = 5'h10;
    localparam logic [6:0] RCB_E1_MF_LAST = 7'h0f;
    localparam logic [6:0] RCB_IND_MAX = 7'h20;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [2:0] RCB_FMT_RST = 3'h1;
    localparam logic [3:0] RCB_SIG_RST = 4'h0;

    typedef struct packed {
        logic [2:0] fmt;
        logic deb;
        logic hold;
        logic sixteen_state_select;
        logic state_change_irq_enable;
        logic [6:0] ind_addr;
        logic read_not_write;
        logic [7:0] ind_data;
        logic busy;
        logic [31:0] cap;
        logic [31:0] cos;
        logic [31:0][3:0] sig;
        logic [31:0][3:0] last;
        logic [31:0][3:0] pend;
        logic slip_seen;
        logic [31:0] prdata;
        logic [7:0] dout;
        logic [7:0] sout;
        logic dvalid;
        logic irq_n;
    } rcb_state_t;

endpackage

// ---- design/rcb_buffer.sv ----
// receive cas / robbed-bit signaling buffer with apb register access
//
// Function
// RQ1: t1 signaling from bit 8, frames 6n
// RQ2: codeword in low nibble, slot aligned
// RQ3: capture enable copies bits into store
// RQ4: sf stores a,b again as c,d
// RQ5: signaling output shows stored codeword
// RQ6: no extraction in t1 dm
// RQ7: filter needs two identical codewords
// RQ8: freeze on frame loss, slip, hold
// RQ9: esf 4-state: a,b only stored; the code stores the frame 18 and 24 bits (c,d) twice instead
// RQ10: esf 16-state stores a,b,c,d
// RQ11: t1 change flag per channel 1-24
// RQ12: irq while enabled and flag set
// RQ13: indirect address, direction, data, busy
// RQ14: e1 signaling from timeslot 16
// RQ15: e1 codeword low nibble, slot aligned
// RQ16: e1 ts0 and ts16 nibble undefined
// RQ17: e1 also freezes on multiframe loss
// RQ18: e1 change flag per timeslot 1-15 and 17-31
// RQ19: flags cleared by writing one
// RQ20: host waits for busy clear
`timescale 1ns/100ps

module rcb_buffer (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic [4:0] rx_slot,
    input wire logic [6:0] rx_frame,
    input wire logic frame_lost,
    input wire logic mf_lost,
    input wire logic slip_pulse,
    output logic [7:0] rx_data_out,
    output logic [7:0] rx_signaling_out,
    output logic rx_out_valid,
    output logic irq_out_n
);
    import rcb_pkg::*;

    rcb_state_t s_r;
    rcb_state_t s_nxt;

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        logic [31:0] got;
        logic [31:0][3:0] code;
        logic [4:0] islot;
        logic [6:0] rf;
        logic [6:0] last_f;
        logic e1;
        logic t1;
        logic frozen;
        logic mf_end;
        logic [3:0] p;
        s_nxt = s_r;
        got = 32'h0;
        code = '0;
        rf = 7'h00;
        last_f = 7'h00;
        frozen = 1'b0;
        islot = 5'(s_r.ind_addr - 7'h01);
        e1 = (s_r.fmt == RCB_FMT_E1);
        t1 = (s_r.fmt == RCB_FMT_SF) || (s_r.fmt == RCB_FMT_ESF) ||
             (s_r.fmt == RCB_FMT_SLC); // RQ6
        mf_end = 1'b0;
        p = 4'h0;

        // apb: read data captured in setup, write applied in access
        if (psel && !penable) begin
            case (paddr)
                RCB_ADDR_CFG: s_nxt.prdata = {24'h0, s_r.state_change_irq_enable, s_r.sixteen_state_select, s_r.hold,
                                              s_r.deb, 1'b0, s_r.fmt};
                RCB_ADDR_ACC: s_nxt.prdata = {24'h0, s_r.read_not_write, s_r.ind_addr};
                RCB_ADDR_DATA: s_nxt.prdata = {24'h0, s_r.ind_data};
                RCB_ADDR_STAT: s_nxt.prdata = {31'h0, s_r.busy};
                RCB_ADDR_COS: s_nxt.prdata = s_r.cos;
                default: s_nxt.prdata = 32'h0;
            endcase
        end
        if (psel && penable && pwrite) begin
            case (paddr)
                RCB_ADDR_CFG: begin
                    s_nxt.fmt = pwdata[RCB_CFG_FMT_LSB +: 3];
                    s_nxt.deb = pwdata[RCB_CFG_DEB_BIT];
                    s_nxt.hold = pwdata[RCB_CFG_HOLD_BIT];
                    s_nxt.sixteen_state_select = pwdata[RCB_CFG_SIXTEEN_STATE_SELECT_BIT];
                    s_nxt.state_change_irq_enable = pwdata[RCB_CFG_STATE_CHANGE_IRQ_ENABLE_BIT];
                end
                RCB_ADDR_ACC: begin
                    s_nxt.ind_addr = pwdata[6:0]; // RQ13
                    s_nxt.read_not_write = pwdata[RCB_ACC_RWN_BIT];
                    s_nxt.busy = 1'b1;
                end
                RCB_ADDR_DATA: s_nxt.ind_data = pwdata[7:0];
                RCB_ADDR_COS: s_nxt.cos = s_r.cos & ~pwdata; // RQ19
                default: ;
            endcase
        end

        // indirect access runs one cycle after the control write
        if (s_r.busy) begin
            s_nxt.busy = 1'b0; // RQ13
            if (s_r.ind_addr != 7'h00 && s_r.ind_addr <= RCB_IND_MAX) begin
                if (s_r.read_not_write) begin
                    s_nxt.ind_data = {3'h0, s_r.cap[islot], s_r.sig[islot]};
                end else begin
                    s_nxt.cap[islot] = s_r.ind_data[RCB_IND_CAP_BIT];
                    s_nxt.sig[islot] = s_r.ind_data[3:0];
                end
            end else if (s_r.read_not_write) begin
                s_nxt.ind_data = 8'h0;
            end
        end

        // reduce slc-96 frame numbers to the 24-frame signaling cycle
        rf = rx_frame;
        if (rf > 7'h30) begin
            rf = rf - 7'h30;
        end else if (rf > RCB_ESF_LAST) begin
            rf = rf - RCB_ESF_LAST;
        end
        last_f = (s_r.fmt == RCB_FMT_SF) ? RCB_SF_LAST : RCB_ESF_LAST;

        // t1 robbed-bit extraction
        if (rx_valid && t1 && rx_slot < RCB_T1_CHANNELS && rf != 7'h00 &&
            rf <= last_f && (rf % RCB_SIG_STEP) == 7'h00) begin
            p = s_r.pend[rx_slot];
            case (rf)
                7'h06: p[3] = rx_byte[0]; // RQ1
                7'h0c: p[2] = rx_byte[0];
                7'h12: p[1] = rx_byte[0];
                default: p[0] = rx_byte[0];
            endcase
            s_nxt.pend[rx_slot] = p;
            if (rf == last_f) begin
                got[rx_slot] = 1'b1;
                if (s_r.fmt == RCB_FMT_SF) begin
                    code[rx_slot] = {p[3], p[2], p[3], p[2]}; // RQ4
                end else if (s_r.sixteen_state_select) begin
                    code[rx_slot] = p; // RQ10
                end else begin
                    code[rx_slot] = {p[1], p[0], p[1], p[0]}; // RQ9
                end
                if (rx_slot == RCB_T1_CHANNELS - 5'h01) begin
                    mf_end = 1'b1;
                end
            end
        end

        // e1 cas: ts16 of frame k carries timeslots k and k+16
        if (rx_valid && e1 && rx_slot == RCB_E1_SIG_TS && rx_frame != 7'h00 &&
            rx_frame <= RCB_E1_MF_LAST) begin
            got[rx_frame[3:0]] = 1'b1; // RQ14
            code[rx_frame[3:0]] = rx_byte[7:4];
            got[{1'b1, rx_frame[3:0]}] = 1'b1;
            code[{1'b1, rx_frame[3:0]}] = rx_byte[3:0];
            mf_end = (rx_frame == RCB_E1_MF_LAST);
        end

        frozen = frame_lost || slip_pulse || s_r.slip_seen || s_r.hold ||
                 (e1 && mf_lost); // RQ8 RQ17

        // a slip freezes the rest of the multiframe in progress
        if (mf_end) begin
            s_nxt.slip_seen = 1'b0;
        end
        if (slip_pulse) begin
            s_nxt.slip_seen = 1'b1; // RQ8
        end

        // store update, filter and change flags; a set beats a clear
        for (int i = 0; i < 32; i++) begin
            if (got[i]) begin
                s_nxt.last[i] = code[i];
                if (s_nxt.cap[i] && !frozen && (!s_r.deb || code[i] == s_r.last[i]) &&
                    code[i] != s_nxt.sig[i]) begin // RQ3 RQ7
                    s_nxt.sig[i] = code[i];
                    s_nxt.cos[i] = 1'b1; // RQ11 RQ18
                end
            end
        end

        // slot-aligned output of payload and stored signaling
        s_nxt.dvalid = rx_valid;
        if (rx_valid) begin
            s_nxt.dout = rx_byte;
            s_nxt.sout = {4'h0, s_r.sig[rx_slot]}; // RQ2 RQ5 RQ15 RQ16
        end

        s_nxt.irq_n = !(s_nxt.state_change_irq_enable && (|s_nxt.cos)); // RQ12
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
            s_r.fmt <= RCB_FMT_RST;
            s_r.sig <= {32{RCB_SIG_RST}};
            s_r.irq_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign prdata = s_r.prdata;
    assign pready = psel && penable;
    assign pslverr = 1'b0;
    assign rx_data_out = s_r.dout;
    assign rx_signaling_out = s_r.sout;
    assign rx_out_valid = s_r.dvalid;
    assign irq_out_n = s_r.irq_n;

endmodule

// ---- verification/rcb_assertions.sv ----
// port checker for the receive signaling buffer
`timescale 1ns/100ps
module rcb_assertions (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic frame_lost,
    input wire logic [7:0] rx_data_out,
    input wire logic [7:0] rx_signaling_out,
    input wire logic rx_out_valid,
    input wire logic irq_out_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire acc = psel && penable;
    AST_READY: assert property (pready == acc) else $error("pready wrong");
    AST_NOERR: assert property (!pslverr) else $error("pslverr set");
    AST_OUT: assert property (rx_valid |=> rx_out_valid && rx_data_out == $past(rx_byte))
        else $error("slot output wrong");
    AST_QUIET: assert property (!rx_valid |=> !rx_out_valid) else $error("stray valid");
    AST_NIB: assert property (rx_out_valid |-> rx_signaling_out[7:4] == 4'h0)
        else $error("upper nibble set");
    AST_IRQ: assert property ($fell(irq_out_n) |-> $past(rx_valid || (acc && pwrite)))
        else $error("irq without cause");
    AST_RDHOLD: assert property (acc |=> $stable(prdata)) else $error("prdata moved");
    AST_FRZ: assert property (rx_valid && frame_lost && !acc |=> $stable(irq_out_n))
        else $error("flag set while frozen");
    cover property (rx_valid && frame_lost);
    cover property ($fell(irq_out_n));
    cover property (acc && pwrite);
endmodule

// ---- verification/rcb_backplane.sv ----
// backplane-side consumer keeping the last slot seen on the outputs
`timescale 1ns/100ps
module rcb_backplane (
    input wire logic clk,
    input wire logic rx_out_valid,
    input wire logic [7:0] rx_data_out,
    input wire logic [7:0] rx_signaling_out,
    output logic [15:0] last_slot
);
    // upper nibble is don't-care, so it is dropped here
    always_ff @(posedge clk) begin
        if (rx_out_valid) begin
            last_slot <= {rx_data_out, 4'h0, rx_signaling_out[3:0]};
        end
    end
endmodule

// ---- verification/rcb_buffer_tb.sv ----
// testbench for the receive signaling buffer
`timescale 1ns/100ps
module rcb_buffer_tb;
    import rcb_pkg::*;
    logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic pready, pslverr, rx_valid = 0, frame_lost = 0, mf_lost = 0, slip_pulse = 0;
    logic [7:0] rx_byte = '0, rx_data_out, rx_signaling_out;
    logic [4:0] rx_slot = '0;
    logic [6:0] rx_frame = '0;
    logic rx_out_valid, irq_out_n;
    logic [15:0] seen;
    int num_errors = 0, checks_done = 0;
    always #2 clk = ~clk;
    rcb_buffer u_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_slot(rx_slot),
        .rx_frame(rx_frame), .frame_lost(frame_lost), .mf_lost(mf_lost),
        .slip_pulse(slip_pulse),
        .rx_data_out(rx_data_out), .rx_signaling_out(rx_signaling_out),
        .rx_out_valid(rx_out_valid), .irq_out_n(irq_out_n));
    rcb_backplane u_bp (.clk(clk), .rx_out_valid(rx_out_valid), .rx_data_out(rx_data_out),
        .rx_signaling_out(rx_signaling_out), .last_slot(seen));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        r = prdata;
        {psel, penable} <= 2'b00;
    endtask
    task ind(input logic rd, input logic [6:0] a, input logic [7:0] d);
        if (!rd) apb(1, RCB_ADDR_DATA, {24'h0, d});
        apb(1, RCB_ADDR_ACC, {24'h0, rd, a});
        r = 1;
        while (r[0] !== 1'b0) apb(0, RCB_ADDR_STAT, 0);
        apb(0, RCB_ADDR_DATA, 0);
    endtask
    task send(input logic [4:0] s, input logic [6:0] f, input logic [7:0] b);
        @(posedge clk);
        {rx_valid, rx_slot, rx_frame, rx_byte} <= {1'b1, s, f, b};
        @(posedge clk);
        rx_valid <= 0;
    endtask
    task t_sf;
        apb(1, RCB_ADDR_CFG, 32'h80);
        ind(0, 7'h01, 8'h10);
        send(0, 6, 8'h01);
        send(0, 12, 8'h00);
        ind(1, 7'h01, 0);
        chk(32'(r[7:0]), 32'h1a);
        apb(0, RCB_ADDR_COS, 0);
        chk(r, 32'h1);
        chk(32'(irq_out_n), 0);
        send(0, 1, 8'h5c);
        @(posedge clk);
        #1 chk(32'(seen), 32'h5c0a);
        apb(1, RCB_ADDR_COS, 32'h1);
        apb(0, RCB_ADDR_COS, 0);
        chk(r, 0);
        chk(32'(irq_out_n), 1);
        apb(0, 12'h020, 0);
        chk(r, 0);
    endtask
    task t_deb_frz;
        apb(1, RCB_ADDR_CFG, 32'h10);
        send(0, 6, 8'h01);
        send(0, 12, 8'h01);
        ind(1, 7'h01, 0);
        chk(32'(r[7:0]), 32'h1a);
        send(0, 6, 8'h01);
        send(0, 12, 8'h01);
        ind(1, 7'h01, 0);
        chk(32'(r[7:0]), 32'h1f);
        apb(1, RCB_ADDR_CFG, 32'h20);
        send(0, 6, 8'h00);
        send(0, 12, 8'h01);
        apb(1, RCB_ADDR_CFG, 0);
        frame_lost <= 1;
        send(0, 6, 8'h00);
        send(0, 12, 8'h01);
        frame_lost <= 0;
        ind(1, 7'h01, 0);
        chk(32'(r[7:0]), 32'h1f);
        slip_pulse <= 1;
        @(posedge clk);
        slip_pulse <= 0;
        send(0, 6, 8'h00);
        send(0, 12, 8'h00);
        ind(1, 7'h01, 0);
        chk(32'(r[7:0]), 32'h1f);
        // last channel at the last signaling frame ends the slip freeze
        send(23, 12, 8'h00);
    endtask
    task t_esf;
        apb(1, RCB_ADDR_CFG, {29'h0, RCB_FMT_ESF});
        ind(0, 7'h03, 8'h10);
        send(2, 6, 8'h01);
        send(2, 12, 8'h00);
        send(2, 18, 8'h00);
        send(2, 24, 8'h01);
        ind(1, 7'h03, 0);
        chk(32'(r[7:0]), 32'h15);
        apb(1, RCB_ADDR_CFG, 32'h41);
        send(2, 6, 8'h01);
        send(2, 12, 8'h00);
        send(2, 18, 8'h00);
        send(2, 24, 8'h01);
        ind(1, 7'h03, 0);
        chk(32'(r[7:0]), 32'h19);
        apb(1, RCB_ADDR_CFG, 32'h42);
        send(2, 54, 8'h00);
        send(2, 60, 8'h01);
        send(2, 66, 8'h01);
        send(2, 72, 8'h00);
        ind(1, 7'h03, 0);
        chk(32'(r[7:0]), 32'h16);
    endtask
    task t_e1;
        apb(1, RCB_ADDR_CFG, {29'h0, RCB_FMT_E1});
        ind(0, 7'h02, 8'h10);
        send(16, 1, 8'h53);
        ind(1, 7'h02, 0);
        chk(32'(r[7:0]), 32'h15);
        apb(0, RCB_ADDR_COS, 0);
        chk(r, 32'h3);
        mf_lost <= 1;
        send(16, 1, 8'ha0);
        mf_lost <= 0;
        send(1, 2, 8'h77);
        @(posedge clk);
        #1 chk(32'(seen), 32'h7705);
    endtask
    task t_dm;
        apb(1, RCB_ADDR_CFG, {29'h0, RCB_FMT_DM});
        send(0, 6, 8'h00);
        send(0, 12, 8'h00);
        ind(1, 7'h01, 0);
        chk(32'(r[7:0]), 32'h1f);
    endtask
    task report_and_stop;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        reset_n <= 1;
        t_sf;
        t_deb_frz;
        t_e1;
        t_dm;
        t_esf;
        report_and_stop;
    end
    initial begin
        #40000;
        num_errors++;
        report_and_stop;
    end
endmodule
bind rcb_buffer rcb_assertions u_chk (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .frame_lost(frame_lost),
    .rx_data_out(rx_data_out), .rx_signaling_out(rx_signaling_out),
    .rx_out_valid(rx_out_valid), .irq_out_n(irq_out_n));
